// file: verilog/vpic_pkg.sv
// shared constants and types of the vectored priority interrupt controller
package vpic_pkg;
  // ==========================================================================
  // register offsets on the special function register port
  localparam logic [7:0] SPI_SOURCE_ENABLE_ADDR = 8'hA6;
  localparam logic [7:0] IRQ_ENABLE_PRIMARY_ADDR = 8'hA8;
  localparam logic [7:0] PRIORITY_SELECT_LOW_ADDR = 8'hA9;
  localparam logic [7:0] IRQ_ENABLE_SECONDARY_ADDR = 8'hB8;
  localparam logic [7:0] PRIORITY_SELECT_HIGH_ADDR = 8'hB9;
  localparam logic [7:0] REQUEST_FLAGS_ADDR = 8'hC0;
  // ==========================================================================
  // reset values
  localparam logic [7:0] SPI_SOURCE_ENABLE_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // ==========================================================================
  // field positions
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int SPI_MASTER_EN_BIT = 1;
  localparam int SPI_SLAVE_EN_BIT = 0;
  localparam int PRIO_GROUPS = 6;
  localparam int NUM_VECTORS = 14;
  // flag register bits
  localparam int FLAG_T2_EXT = 7;
  localparam int FLAG_T2_OVF = 6;
  localparam int FLAG_WAKE = 5;
  localparam int FLAG_USB = 4;
  localparam int FLAG_USB_WAKE = 3;
  localparam int FLAG_SPI = 2;
  localparam int FLAG_RADIO = 1;
  localparam int FLAG_RADIO_SPI = 0;
  // flags cleared by hardware when vectored
  localparam logic [7:0] AUTO_CLEAR_MASK = 8'h3E;
  // ==========================================================================
  // vector slots, index order equals address order
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP = 8;
  localparam int VI_PIN3 = 0;
  localparam int VI_T0 = 1;
  localparam int VI_CIPHER = 2;
  localparam int VI_T1 = 3;
  localparam int VI_SERIAL = 4;
  localparam int VI_T2 = 5;
  localparam int VI_RSPI = 8;
  localparam int VI_RADIO = 9;
  localparam int VI_SPI = 10;
  localparam int VI_BUS_RESUME_REQUEST = 11;
  localparam int VI_USB = 12;
  localparam int VI_WAKE = 13;
  localparam logic [7:0] NO_LEVEL = 8'h00;

  typedef struct packed {
    logic [7:0] spi_en;
    logic [7:0] en_pri;
    logic [7:0] prio_lo;
    logic [7:0] en_sec;
    logic [7:0] prio_hi;
    logic [7:0] flags;
    logic [3:0] active;
    logic [3:0] vec_idx;
    logic [7:0] rdata;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] prev;
    logic p3_prev;
    logic p4_prev;
    logic p5_prev;
  } vpic_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vpic_sfr_type;
endpackage

// file: verilog/vpic_ctrl.sv
// vectored priority interrupt controller, one clock, special function port
//
// How it works
// R1: enabled pending request vectors core; higher preempts
// R2: fixed vector table, eight byte spacing
// R3: serial receive and transmit share 0x0023
// R4: timer two sources share 0x002B
// R5: spi master and slave share 0x0053
// R6: primary bit seven gates all vectoring
// R7: primary enable bits per source
// R8: secondary enable bits per source
// R9: spi sub enable, resets to slave only
// R10: six groups, each one of four levels
// R11: level from high and low priority bits
// R12: fixed group membership of sources
// R13: flag register exposes pending requests
// R14: hardware clears flags five to one on vector
// R15: wakeup sets flag even when disabled
// R16: software clears flags before standby
// R17: equal level picks lowest vector, no preempt
// R18: shared serial and timer two vectors not auto cleared; the shared spi vector is
`timescale 1ns/100ps
`default_nettype none
module vpic_ctrl
  import vpic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // special function register port
  input wire vpic_sfr_type sfr,
  output logic [7:0] sfr_rdata,
  // level and pulse requests from on-chip logic
  input wire logic timer_zero_overflow,
  input wire logic timer_one_overflow,
  input wire logic timer_two_overflow,
  input wire logic timer_two_external_event,
  input wire logic serial_receive_done,
  input wire logic serial_transmit_done,
  input wire logic cipher_ready_request,
  input wire logic radio_spi_ready,
  input wire logic radio_event_request,
  input wire logic spi_master_complete,
  input wire logic spi_slave_complete,
  input wire logic bus_resume_request,
  input wire logic bus_device_request,
  input wire logic internal_wakeup_request,
  // external pins
  input wire logic port_pin_three,
  input wire logic port_pin_four,
  // core side
  output logic irq_valid,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic [1:0] active_level
);
  vpic_state_type s_q, s_d;
  logic [NUM_VECTORS-1:0] pend;
  logic [NUM_VECTORS-1:0] ven;
  logic [2:0] grp [NUM_VECTORS];
  logic [1:0] lvl [NUM_VECTORS];
  logic [7:0] set_f;
  logic p3_fall, p4_fall, rad_edge, spi_edge;
  logic found;
  logic [3:0] best;
  logic [1:0] best_lvl;

  // group per vector slot; slots 6,7 are unused and never pend
  localparam logic [2:0] GRP_TAB [NUM_VECTORS] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
    3'h0, 3'h0, 3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5}; // R12
  // cipher slot sits in group two with the spi slot; pin four rides in the cipher slot

  // ==========================================================================
  // edge detection, pins pass two flops first
  always_comb begin
    p3_fall = s_q.p3_prev & ~s_q.sync_a[1];
    p4_fall = s_q.p4_prev & ~s_q.sync_b[1];
    rad_edge = radio_event_request ^ s_q.prev[0]; // R2
    spi_edge = ((spi_master_complete ^ s_q.prev[1]) & s_q.spi_en[SPI_MASTER_EN_BIT]) |
      ((spi_slave_complete ^ s_q.p5_prev) & s_q.spi_en[SPI_SLAVE_EN_BIT]); // R5 R9
    set_f = ZERO_RST;
    set_f[FLAG_T2_EXT] = timer_two_external_event;
    set_f[FLAG_T2_OVF] = timer_two_overflow;
    set_f[FLAG_WAKE] = internal_wakeup_request; // R15
    set_f[FLAG_USB] = bus_device_request;
    set_f[FLAG_USB_WAKE] = bus_resume_request;
    set_f[FLAG_SPI] = spi_edge;
    set_f[FLAG_RADIO] = rad_edge;
    set_f[FLAG_RADIO_SPI] = radio_spi_ready;
  end

  // ==========================================================================
  // pending and enable per vector slot
  always_comb begin
    pend = '0;
    ven = '0;
    pend[VI_PIN3] = ~s_q.sync_a[1] | p3_fall;
    ven[VI_PIN3] = s_q.en_pri[0]; // R7
    pend[VI_T0] = timer_zero_overflow;
    ven[VI_T0] = s_q.en_pri[1];
    // pin four, low or falling, shares the cipher slot, its enable and its group
    pend[VI_CIPHER] = ~cipher_ready_request | ~s_q.sync_b[1] | p4_fall; // R7
    ven[VI_CIPHER] = s_q.en_pri[2];
    pend[VI_T1] = timer_one_overflow;
    ven[VI_T1] = s_q.en_pri[3];
    pend[VI_SERIAL] = serial_receive_done | serial_transmit_done; // R3
    ven[VI_SERIAL] = s_q.en_pri[4];
    pend[VI_T2] = (s_q.flags[FLAG_T2_OVF] & s_q.en_pri[5]) |
      (s_q.flags[FLAG_T2_EXT] & s_q.en_sec[7]); // R4
    ven[VI_T2] = 1'b1;
    pend[VI_RSPI] = s_q.flags[FLAG_RADIO_SPI];
    ven[VI_RSPI] = s_q.en_sec[0]; // R8
    pend[VI_RADIO] = s_q.flags[FLAG_RADIO];
    ven[VI_RADIO] = s_q.en_sec[1];
    pend[VI_SPI] = s_q.flags[FLAG_SPI];
    ven[VI_SPI] = s_q.en_sec[2];
    pend[VI_BUS_RESUME_REQUEST] = s_q.flags[FLAG_USB_WAKE];
    ven[VI_BUS_RESUME_REQUEST] = s_q.en_sec[3];
    pend[VI_USB] = s_q.flags[FLAG_USB];
    ven[VI_USB] = s_q.en_sec[4];
    pend[VI_WAKE] = s_q.flags[FLAG_WAKE];
    ven[VI_WAKE] = s_q.en_sec[5];
  end

  // ==========================================================================
  // level per slot from the two priority registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VECTORS; gi++) begin : g_lvl
      assign grp[gi] = GRP_TAB[gi];
      assign lvl[gi] = {s_q.prio_hi[grp[gi]], s_q.prio_lo[grp[gi]]}; // R10 R11
    end
  endgenerate

  // highest level wins, ties go to the lowest slot
  always_comb begin
    found = 1'b0;
    best = 4'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < NUM_VECTORS; i++) begin
      if (pend[i] && ven[i] && (!found || lvl[i] > best_lvl)) begin // R17
        found = 1'b1;
        best = 4'(i);
        best_lvl = lvl[i];
      end
    end
  end

  // active holds one bit per level in service
  logic [1:0] top_active;
  logic preempt_ok;
  always_comb begin
    top_active = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (s_q.active[l]) begin
        top_active = 2'(l);
      end
    end
    preempt_ok = (s_q.active == 4'h0) || (best_lvl > top_active); // R1 R17
  end

  assign irq_valid = found && s_q.en_pri[GLOBAL_ENABLE_BIT] && preempt_ok; // R6
  assign irq_vector = VEC_BASE + 16'({s_q.vec_idx, 3'h0}); // R2
  assign active_level = top_active;
  assign sfr_rdata = s_q.rdata;

  // ==========================================================================
  // next state
  logic [7:0] clr_f;
  always_comb begin
    s_d = s_q;
    clr_f = ZERO_RST;
    s_d.sync_a = {s_q.sync_a[0], port_pin_three};
    s_d.sync_b = {s_q.sync_b[0], port_pin_four};
    s_d.p3_prev = s_q.sync_a[1];
    s_d.p4_prev = s_q.sync_b[1];
    s_d.prev = {spi_master_complete, radio_event_request};
    s_d.p5_prev = spi_slave_complete;
    s_d.vec_idx = best;
    if (irq_valid && irq_ack && s_q.vec_idx == best) begin
      s_d.active[best_lvl] = 1'b1;
      case (best)
        VI_RADIO: clr_f[FLAG_RADIO] = 1'b1; // R14
        VI_SPI: clr_f[FLAG_SPI] = 1'b1;
        VI_BUS_RESUME_REQUEST: clr_f[FLAG_USB_WAKE] = 1'b1;
        VI_USB: clr_f[FLAG_USB] = 1'b1;
        VI_WAKE: clr_f[FLAG_WAKE] = 1'b1;
        default: clr_f = ZERO_RST; // R18
      endcase
    end else if (irq_return) begin
      s_d.active[top_active] = 1'b0;
    end
    if (sfr.wr) begin
      case (sfr.addr)
        SPI_SOURCE_ENABLE_ADDR: s_d.spi_en = {6'h00, sfr.wdata[1:0]}; // R9
        IRQ_ENABLE_PRIMARY_ADDR: s_d.en_pri = sfr.wdata & 8'hBF;
        PRIORITY_SELECT_LOW_ADDR: s_d.prio_lo = sfr.wdata & 8'h3F;
        IRQ_ENABLE_SECONDARY_ADDR: s_d.en_sec = sfr.wdata & 8'hBF;
        PRIORITY_SELECT_HIGH_ADDR: s_d.prio_hi = sfr.wdata & 8'h3F;
        REQUEST_FLAGS_ADDR: s_d.flags = sfr.wdata;
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    // set wins over any clear in the same cycle
    s_d.flags = (s_d.flags & ~clr_f) | set_f; // R13 R15
    s_d.rdata = ZERO_RST;
    if (sfr.rd) begin
      case (sfr.addr)
        SPI_SOURCE_ENABLE_ADDR: s_d.rdata = s_q.spi_en;
        IRQ_ENABLE_PRIMARY_ADDR: s_d.rdata = s_q.en_pri;
        PRIORITY_SELECT_LOW_ADDR: s_d.rdata = s_q.prio_lo;
        IRQ_ENABLE_SECONDARY_ADDR: s_d.rdata = s_q.en_sec;
        PRIORITY_SELECT_HIGH_ADDR: s_d.rdata = s_q.prio_hi;
        REQUEST_FLAGS_ADDR: s_d.rdata = s_q.flags;
        default: s_d.rdata = ZERO_RST;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.spi_en <= SPI_SOURCE_ENABLE_RST;
      s_q.sync_a <= 2'h3;
      s_q.sync_b <= 2'h3;
      s_q.p3_prev <= 1'b1;
      s_q.p4_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // checks
  a_global_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.en_pri[GLOBAL_ENABLE_BIT] |-> !irq_valid) else $error("vector while globally disabled"); // R6
  a_auto_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_valid && irq_ack && s_q.vec_idx == VI_USB && best == VI_USB && !bus_device_request)
    |=> !s_q.flags[FLAG_USB]) else $error("usb flag not cleared on vector"); // R14
  a_keep_t2: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.flags[FLAG_T2_OVF] && !(sfr.wr && sfr.addr == REQUEST_FLAGS_ADDR))
    |=> s_q.flags[FLAG_T2_OVF]) else $error("timer two flag lost"); // R14
  a_wake_set: assert property (@(posedge clk) disable iff (sys_rst)
    internal_wakeup_request |=> s_q.flags[FLAG_WAKE]) else $error("wakeup flag not set"); // R15
  a_no_equal_preempt: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.active != 4'h0 && best_lvl <= top_active) |-> !irq_valid) else $error("equal level preempted"); // R17
  a_vector_slot: assert property (@(posedge clk) disable iff (sys_rst)
    irq_valid |-> irq_vector[2:0] == 3'h3) else $error("vector off slot"); // R2
  a_spi_reset: assert property (@(posedge clk)
    $fell(sys_rst) |-> s_q.spi_en == 8'h01) else $error("spi enable reset wrong"); // R9
  a_level_pick: assert property (@(posedge clk) disable iff (sys_rst)
    (found && pend[VI_T1] && ven[VI_T1] && lvl[VI_T1] == 2'h3) |-> best_lvl == 2'h3)
    else $error("highest level not chosen"); // R11
endmodule
`default_nettype wire

// file: dv/vpic_core_model.sv
// core side model: takes offered vectors and ends routines on request
`timescale 1ns/100ps
`default_nettype none
module vpic_core_model
  import vpic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controller side
  input wire logic irq_valid,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  output logic irq_return,
  // bench control and record
  input wire logic ack_en,
  input wire logic ret_req,
  output logic [15:0] taken_vec,
  output logic [7:0] n_taken
);
  logic seen_q;
  // ==========================================================================
  // handshake
  // acks only once the vector stood a full cycle; ack_en low stalls the core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      taken_vec <= 16'h0000;
      n_taken <= 8'h00;
    end else begin
      irq_return <= ret_req;
      irq_ack <= 1'b0;
      seen_q <= irq_valid && !irq_ack;
      if (irq_valid && seen_q && ack_en && !irq_ack) begin
        irq_ack <= 1'b1;
        seen_q <= 1'b0;
        taken_vec <= irq_vector;
        n_taken <= n_taken + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_vectored_priority_interrupt_ctrl.sv
// self-checking bench of the vectored priority interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb_vectored_priority_interrupt_ctrl
  import vpic_pkg::*;
();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  vpic_sfr_type sfr = '0;
  logic [7:0] sfr_rdata;
  logic [13:0] req = '0;
  logic irq_valid, irq_ack, irq_return;
  logic ack_en = 1'b1;
  logic ret_req = 1'b0;
  logic pin_four = 1'b1;
  logic [15:0] irq_vector, taken_vec;
  logic [1:0] active_level, lv0, lv1;
  logic [7:0] n_taken, n0;
  logic [7:0] m [logic [7:0]];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int first;
  // ==========================================================================
  // source table: vector, primary and secondary enables, kind, flag bit
  localparam logic [15:0] VEC [14] = '{16'h0003, 16'h000B, 16'h001B, 16'h0023, 16'h0023, 16'h002B, 16'h002B,
    16'h0043, 16'h004B, 16'h0053, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
  localparam logic [7:0] ENP [14] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h10, 8'h20, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [7:0] ENS [14] = '{0, 0, 0, 0, 0, 0, 8'h80, 8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20};
  localparam int KIND [14] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 1, 1, 1};
  localparam int FB [14] = '{-1, -1, -1, -1, -1, 6, 7, 0, 1, 2, 2, 3, 4, 5};
  localparam logic [7:0] AL [7] = '{8'hA6, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hC0, 8'hA7};

  always #50 clk = ~clk;

  vpic_ctrl i_vpic_ctrl (.clk(clk), .sys_rst(sys_rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .timer_zero_overflow(req[1]), .timer_one_overflow(req[2]), .timer_two_overflow(req[5]),
    .timer_two_external_event(req[6]), .serial_receive_done(req[3]), .serial_transmit_done(req[4]),
    .cipher_ready_request(1'b1), .radio_spi_ready(req[7]), .radio_event_request(req[8]),
    .spi_master_complete(req[9]), .spi_slave_complete(req[10]), .bus_resume_request(req[11]),
    .bus_device_request(req[12]), .internal_wakeup_request(req[13]), .port_pin_three(~req[0]),
    .port_pin_four(pin_four), .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .irq_return(irq_return), .active_level(active_level));

  vpic_core_model i_vpic_core_model (.clk(clk), .sys_rst(sys_rst), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return), .ack_en(ack_en),
    .ret_req(ret_req), .taken_vec(taken_vec), .n_taken(n_taken));

  // ==========================================================================
  // checks and bus tasks
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'hA8, 8'hB8: msk = 8'hBF;
      8'hA9, 8'hB9: msk = 8'h3F;
      default: msk = 8'hFF;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    if (m.exists(a)) m[a] = d & msk(a);
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk);
    sfr.rd = 1'b0;
    chk_reg("register", m.exists(a) ? m[a] : 8'h00, sfr_rdata);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // waits bounded for one new vector, then checks it and the count
  task automatic take(input logic [15:0] e);
    logic [7:0] c0;
    c0 = n_taken;
    for (int i = 0; i < 30 && n_taken == c0; i++) @(negedge clk);
    // the controller samples the ack one edge after the core raised it
    @(negedge clk);
    chk_vec("vector", e, taken_vec);
    chk_reg("taken", c0 + 8'h01, n_taken);
  endtask

  task automatic ret();
    @(negedge clk);
    ret_req = 1'b1;
    @(negedge clk);
    ret_req = 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(32'h38C0C47D));
    for (int i = 0; i < 6; i++) m[AL[i]] = (i == 0) ? 8'h01 : 8'h00;
    idle(4);
    sys_rst = 1'b0;
    for (int i = 0; i < 7; i++) rd(AL[i]);
    for (int i = 0; i < 5; i++) begin
      wr(AL[i], 8'($urandom) & ((i == 0) ? 8'h03 : 8'hFF));
      rd(AL[i]);
    end
    for (int i = 1; i < 5; i++) wr(AL[i], 8'h00);
    wr(8'hA6, 8'h03);
    // wakeup with its enable clear still raises the flag
    req[13] = 1'b1;
    idle(1);
    req[13] = 1'b0;
    idle(3);
    m[8'hC0] = 8'h20;
    rd(8'hC0);
    wr(8'hC0, 8'h00);
    for (int s = 0; s < 14; s++) begin
      wr(8'hA8, ENP[s]);
      wr(8'hB8, ENS[s]);
      n0 = n_taken;
      req[s] = (KIND[s] == 2) ? ~req[s] : 1'b1;
      if (KIND[s] == 1) begin
        idle(1);
        req[s] = 1'b0;
      end
      idle(6);
      chk_reg("gated", n0, n_taken);
      wr(8'hA8, ENP[s] | 8'h80);
      take(VEC[s]);
      if (FB[s] >= 0) begin
        idle(2);
        m[8'hC0] = 8'(1 << FB[s]) & ~AUTO_CLEAR_MASK;
        rd(8'hC0);
      end
      if (KIND[s] == 0) req[s] = 1'b0;
      idle(3);
      wr(8'hC0, 8'h00);
      ret();
    end
    wr(8'hB8, 8'h00);
    // pin four low vectors through the shared cipher slot
    wr(8'hA8, 8'h84);
    pin_four = 1'b0;
    take(16'h0013);
    pin_four = 1'b1;
    idle(3);
    ret();
    for (int k = 0; k < 4; k++) begin
      wr(8'hA9, 8'($urandom));
      wr(8'hB9, 8'($urandom));
      wr(8'hA8, 8'h8A);
      lv0 = {m[8'hB9][1], m[8'hA9][1]};
      lv1 = {m[8'hB9][3], m[8'hA9][3]};
      first = (lv1 > lv0) ? 2 : 1;
      req[1] = 1'b1;
      req[2] = 1'b1;
      take((first == 2) ? 16'h001B : 16'h000B);
      chk_reg("level", {6'h00, (first == 2) ? lv1 : lv0}, {6'h00, active_level});
      req[first] = 1'b0;
      n0 = n_taken;
      idle(5);
      chk_reg("taken", n0, n_taken);
      ret();
      take((first == 2) ? 16'h000B : 16'h001B);
      req[3 - first] = 1'b0;
      ret();
    end
    // group three at top level preempts a slow-acked timer zero routine
    wr(8'hA9, 8'h08);
    wr(8'hB9, 8'h08);
    ack_en = 1'b0;
    req[1] = 1'b1;
    idle(4);
    ack_en = 1'b1;
    take(16'h000B);
    req[2] = 1'b1;
    take(16'h001B);
    chk_reg("level", 8'h03, {6'h00, active_level});
    req[1] = 1'b0;
    req[2] = 1'b0;
    ret();
    ret();
    idle(4);
    finish_test();
  end
endmodule
`default_nettype wire
